// *** logic/acb_params.svh ***
// constants for the serial control port and self-test block
`ifndef ACB_PARAMS_SVH
`define ACB_PARAMS_SVH

// ****************************************
// register addresses
// ****************************************
`define ACB_ADDR_CFG      13'h000
`define ACB_ADDR_ID       13'h001
`define ACB_ADDR_PAT      13'h00d
`define ACB_ADDR_BST      13'h00e
`define ACB_ADDR_RES      13'h024
`define ACB_ADDR_XFER     13'h0ff

// ****************************************
// field positions and values
// ****************************************
`define ACB_CFG_RESET     8'h18
`define ACB_CFG_LSB_HI    6
`define ACB_CFG_LSB_LO    1
`define ACB_CFG_SRST_HI   5
`define ACB_CFG_SRST_LO   2
`define ACB_XFER_CMD      8'h01
`define ACB_BST_GO_BIT    0
`define ACB_BST_RST_BIT   2
`define ACB_PAT_RST_LONG  4
`define ACB_PAT_RST_SHORT 5
`define ACB_RES_PASS_BIT  0
`define ACB_CTL_RESET     8'h00
// arbitrary identification value
`define ACB_CHIP_ID       8'h5a

// ****************************************
// self-test and pattern generators
// ****************************************
`define ACB_BST_CYCLES    10'h200
`define ACB_BST_LAST      9'h1ff
`define ACB_BST_SEED      16'hace1
`define ACB_CRC_INIT      16'hffff
`define ACB_CRC_POLY      16'h1021
`define ACB_PRS_LONG_SEED 23'h7fffff
`define ACB_PRS_SHRT_SEED 9'h1ff
`define ACB_MIDSCALE      14'h2000
`define ACB_CHECKER       14'h2aaa

`endif

// *** logic/acb_pkg.sv ***
// types for the serial control port and self-test block
package acb_pkg;

    // ****************************************
    // link phase
    // ****************************************
    typedef enum logic [0:0] {
        ACB_LNK_INSTR = 1'b0,
        ACB_LNK_DATA  = 1'b1
    } acb_link_e;

    // ****************************************
    // output pattern selection
    // ****************************************
    typedef enum logic [3:0] {
        ACB_PAT_OFF      = 4'h0,
        ACB_PAT_MID      = 4'h1,
        ACB_PAT_POS      = 4'h2,
        ACB_PAT_NEG      = 4'h3,
        ACB_PAT_CHECK    = 4'h4,
        ACB_PAT_PRS_LONG = 4'h5,
        ACB_PAT_PRS_SHRT = 4'h6,
        ACB_PAT_TOGGLE   = 4'h7
    } acb_pat_e;

    // shadowed control pair
    typedef struct packed {
        logic [7:0] pattern;
        logic [7:0] bist;
    } acb_ctl_s;

    // levels caught from the straps
    typedef struct packed {
        logic strap_mode;
        logic powerdown;
        logic twos;
    } acb_strap_s;

endpackage : acb_pkg

// *** logic/acb_spi_bist.sv ***
// serial control port, output test patterns and datapath self-test
// Overview of operation
// - self-test feeds generator words into datapath and accumulates a signature of the generator words
// - self-test runs exactly 512 sample cycles then stops by itself
// - at the end the signature is compared; result bit 0 set on match else cleared
// - writing 0x05 to 0x0e then 0x01 to 0xff starts the test: bit 0 go, bit 2 restart
// - data outputs carry the generator words while the test runs
// - start without restart continues the generator; signature then mismatches
// - active pattern test replaces converter samples, passing through the formatter
// - bits 4 and 5 of the pattern register restart the two generators
// - patterns advance only on the sample clock
// - frame starts on first serial clock rise after select falls
// - with length code 3, select held low streams successive bytes without limit
// - select raised between bytes stalls unless streaming; the frame resumes when it returns low
// - select high floats the serial pins; held high at reset release it enables the strap functions
// - each frame opens with a 16-bit instruction carrying the length code
// - data is bytes; instruction bit 15 selects read or write
// - data line is input except during readback data phase
// - shift msb first after power-up, lsb first when configured
// - serial clock and select are inputs only; serial clock times every shift
// - strap mode: data pin high at power-up means power-down
// - strap mode: clock pin high selects twos complement, low offset binary
// - writes to 0x0d and 0x0e are shadowed until 0x01 to 0xff; bit self-clears
// - port configuration bits are mirrored in both nibbles
`timescale 1ns/10ps
`include "acb_params.svh"

module acb_spi_bist
    import acb_pkg::*;
(
    // sample clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    // serial port pins
    input  wire logic        clock_or_format_strap_pin_i,
    input  wire logic        port_select_bar_i,
    input  wire logic        data_io_or_powerdown_strap_pin_i,
    output logic             data_io_or_powerdown_strap_pin_o,
    output logic             data_io_or_powerdown_strap_pin_oe_o,
    // converter datapath
    input  wire logic [13:0] sample_i,
    output logic      [13:0] data_o,
    // status
    output logic             powerdown_strap_o,
    output logic             format_select_strap_o,
    output logic             strap_mode_o,
    output logic             bist_running_o
);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [13:0] word);
        logic [15:0] c;
        logic [15:0] d;
        c = crc;
        d = {2'h0, word};
        for (int i = 15; i >= 0; i--) begin
            c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ `ACB_CRC_POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction : crc_step

    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_step

    function automatic logic [15:0] golden_sig();
        logic [15:0] c;
        logic [15:0] l;
        c = `ACB_CRC_INIT;
        l = `ACB_BST_SEED;
        for (int i = 0; i < 512; i++) begin
            c = crc_step(c, l[13:0]);
            l = lfsr_step(l);
        end
        return c;
    endfunction : golden_sig

    function automatic logic [7:0] reg_read(input logic [12:0] a, input logic [7:0] cfg,
                                            input acb_ctl_s sh, input logic res);
        case (a)
            `ACB_ADDR_CFG: reg_read = cfg;
            `ACB_ADDR_ID:  reg_read = `ACB_CHIP_ID;
            `ACB_ADDR_PAT: reg_read = sh.pattern;
            `ACB_ADDR_BST: reg_read = sh.bist;
            `ACB_ADDR_RES: reg_read = {7'h00, res};
            default:       reg_read = 8'h00;
        endcase
    endfunction : reg_read

    localparam logic [15:0] GOLDEN = golden_sig();

    // ****************************************
    // declarations
    // ****************************************
    logic             rst_hold_reg;
    logic             link_abort;
    logic             sel_low;
    acb_link_e        state_reg;
    logic [3:0]       bit_cnt_reg;
    logic [15:0]      shift_reg;
    logic             rw_reg;
    logic             stream_reg;
    logic [1:0]       left_reg;
    logic [12:0]      addr_reg;
    logic [7:0]       rd_byte_reg;
    logic             sdo_reg;
    logic             lsb_first_reg;
    logic [7:0]       cfg_reg;
    acb_ctl_s         shadow_reg;
    logic             xfer_tgl_reg;
    logic             res_s1_reg;
    logic             res_s2_reg;
    logic [15:0]      ins_next;
    logic [7:0]       byte_in;
    logic             byte_done;
    logic             more_bytes;
    logic [12:0]      addr_next;
    logic [7:0]       rd_next;
    logic [7:0]       rd_first;
    logic [2:0]       xfer_sync_reg;
    logic             xfer_evt;
    acb_ctl_s         act_reg;
    logic             bst_run_reg;
    logic [8:0]       bst_cnt_reg;
    logic [15:0]      bst_lfsr_reg;
    logic [15:0]      crc_reg;
    logic [15:0]      crc_next;
    logic             bst_pass_reg;
    logic             bst_start;
    logic [22:0]      prs_long_reg;
    logic [8:0]       prs_short_reg;
    logic             tog_reg;
    logic [13:0]      pat_word;
    logic [13:0]      data_reg;
    logic [1:0]       pin_sel_reg;
    logic [1:0]       pin_dio_reg;
    logic [1:0]       pin_clk_reg;
    logic [1:0]       strap_cnt_reg;
    acb_strap_s       strap_reg;

    // ****************************************
    // reset handed to the link side
    // ****************************************
    always_ff @(posedge clock_i) begin
        rst_hold_reg <= ~reset_n_i;
    end

    // frame dropped on select high except at a counted byte boundary
    assign link_abort = rst_hold_reg | (port_select_bar_i &
                        ~((state_reg == ACB_LNK_DATA) && (bit_cnt_reg == 4'h0) && !stream_reg));
    assign sel_low    = ~port_select_bar_i;

    // ****************************************
    // link decode
    // ****************************************
    always_comb begin
        ins_next   = lsb_first_reg ? {data_io_or_powerdown_strap_pin_i, shift_reg[15:1]}
                                   : {shift_reg[14:0], data_io_or_powerdown_strap_pin_i};
        byte_in    = lsb_first_reg ? {data_io_or_powerdown_strap_pin_i, shift_reg[7:1]}
                                   : {shift_reg[6:0], data_io_or_powerdown_strap_pin_i};
        byte_done  = sel_low && (state_reg == ACB_LNK_DATA) && (bit_cnt_reg == 4'h7);
        more_bytes = stream_reg || (left_reg != 2'h0);
        addr_next  = lsb_first_reg ? addr_reg + 13'h001 : addr_reg - 13'h001;
        rd_next    = reg_read(addr_next, cfg_reg, shadow_reg, res_s2_reg);
        rd_first   = reg_read(ins_next[12:0], cfg_reg, shadow_reg, res_s2_reg);
    end

    // ****************************************
    // link frame engine
    // ****************************************
    always_ff @(posedge clock_or_format_strap_pin_i or posedge link_abort) begin
        if (link_abort) begin
            state_reg   <= ACB_LNK_INSTR;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 16'h0000;
            rw_reg      <= 1'b0;
            stream_reg  <= 1'b0;
            left_reg    <= 2'h0;
            addr_reg    <= 13'h0000;
            rd_byte_reg <= 8'h00;
            sdo_reg     <= 1'b0;
        end else if (sel_low) begin
            shift_reg <= ins_next;
            case (state_reg)
                ACB_LNK_INSTR: begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == 4'hf) begin
                        state_reg   <= ACB_LNK_DATA;
                        bit_cnt_reg <= 4'h0;
                        rw_reg      <= ins_next[15];
                        stream_reg  <= (ins_next[14:13] == 2'h3);
                        left_reg    <= ins_next[14:13];
                        addr_reg    <= ins_next[12:0];
                        rd_byte_reg <= rd_first;
                        sdo_reg     <= lsb_first_reg ? rd_first[0] : rd_first[7];
                    end
                end
                ACB_LNK_DATA: begin
                    if (bit_cnt_reg == 4'h7) begin
                        bit_cnt_reg <= 4'h0;
                        if (more_bytes) begin
                            addr_reg    <= addr_next;
                            left_reg    <= stream_reg ? left_reg : left_reg - 2'h1;
                            rd_byte_reg <= rd_next;
                            sdo_reg     <= lsb_first_reg ? rd_next[0] : rd_next[7];
                        end else begin
                            state_reg <= ACB_LNK_INSTR;
                            rw_reg    <= 1'b0;
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        sdo_reg     <= lsb_first_reg ? rd_byte_reg[bit_cnt_reg[2:0] + 3'h1]
                                                     : rd_byte_reg[3'h6 - bit_cnt_reg[2:0]];
                    end
                end
                default: begin
                    state_reg <= ACB_LNK_INSTR;
                end
            endcase
        end
    end

    // ****************************************
    // link registers and shadows
    // ****************************************
    always_ff @(posedge clock_or_format_strap_pin_i or posedge rst_hold_reg) begin
        if (rst_hold_reg) begin
            lsb_first_reg <= 1'b0;
            cfg_reg       <= `ACB_CFG_RESET;
            shadow_reg    <= {`ACB_CTL_RESET, `ACB_CTL_RESET};
            xfer_tgl_reg  <= 1'b0;
        end else if (byte_done && !rw_reg) begin
            case (addr_reg)
                `ACB_ADDR_CFG: begin
                    if (byte_in[`ACB_CFG_SRST_HI] | byte_in[`ACB_CFG_SRST_LO]) begin
                        lsb_first_reg <= 1'b0;
                        cfg_reg       <= `ACB_CFG_RESET;
                        shadow_reg    <= {`ACB_CTL_RESET, `ACB_CTL_RESET};
                    end else begin
                        lsb_first_reg <= byte_in[`ACB_CFG_LSB_HI] | byte_in[`ACB_CFG_LSB_LO];
                        cfg_reg       <= `ACB_CFG_RESET | {1'b0, byte_in[`ACB_CFG_LSB_HI] | byte_in[`ACB_CFG_LSB_LO],
                                         4'h0, byte_in[`ACB_CFG_LSB_HI] | byte_in[`ACB_CFG_LSB_LO], 1'b0};
                    end
                end
                `ACB_ADDR_PAT: shadow_reg.pattern <= byte_in;
                `ACB_ADDR_BST: shadow_reg.bist    <= byte_in;
                `ACB_ADDR_XFER: begin
                    if (byte_in == `ACB_XFER_CMD) begin
                        xfer_tgl_reg <= ~xfer_tgl_reg;
                    end
                end
                default: begin
                    cfg_reg <= cfg_reg;
                end
            endcase
        end
    end

    // result level into link domain
    always_ff @(posedge clock_or_format_strap_pin_i or posedge rst_hold_reg) begin
        if (rst_hold_reg) begin
            res_s1_reg <= 1'b0;
            res_s2_reg <= 1'b0;
        end else begin
            res_s1_reg <= bst_pass_reg;
            res_s2_reg <= res_s1_reg;
        end
    end

    // serial data pin
    assign data_io_or_powerdown_strap_pin_o  = sdo_reg;
    assign data_io_or_powerdown_strap_pin_oe_o = sel_low && (state_reg == ACB_LNK_DATA) && rw_reg;

    a_dio_release: assert property (@(posedge clock_or_format_strap_pin_i) disable iff (rst_hold_reg)
        (state_reg == ACB_LNK_INSTR || !rw_reg) |-> !data_io_or_powerdown_strap_pin_oe_o)
        else $error("data line driven outside readback data");

    a_addr_step: assert property (@(posedge clock_or_format_strap_pin_i) disable iff (link_abort)
        (byte_done && more_bytes && !lsb_first_reg) |=> addr_reg == $past(addr_reg) - 13'h001)
        else $error("address not stepped after data byte");

    // ****************************************
    // transfer command crossing
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            xfer_sync_reg <= 3'h0;
        end else begin
            xfer_sync_reg <= {xfer_sync_reg[1:0], xfer_tgl_reg};
        end
    end
    assign xfer_evt = xfer_sync_reg[2] ^ xfer_sync_reg[1];

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            act_reg <= {`ACB_CTL_RESET, `ACB_CTL_RESET};
        end else if (xfer_evt) begin
            act_reg <= shadow_reg;
        end
    end

    a_xfer_apply: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        xfer_evt |=> act_reg == $past(shadow_reg))
        else $error("shadow copy not applied on transfer");

    // ****************************************
    // self-test sequencer
    // ****************************************
    assign bst_start = xfer_evt && shadow_reg.bist[`ACB_BST_GO_BIT] && !bst_run_reg;
    assign crc_next  = crc_step(crc_reg, bst_lfsr_reg[13:0]);

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            bst_run_reg  <= 1'b0;
            bst_cnt_reg  <= 9'h000;
            bst_lfsr_reg <= `ACB_BST_SEED;
            crc_reg      <= `ACB_CRC_INIT;
            bst_pass_reg <= 1'b0;
        end else if (bst_start) begin
            bst_run_reg <= 1'b1;
            bst_cnt_reg <= 9'h000;
            crc_reg     <= `ACB_CRC_INIT;
            if (shadow_reg.bist[`ACB_BST_RST_BIT]) begin
                bst_lfsr_reg <= `ACB_BST_SEED;
            end
        end else if (bst_run_reg) begin
            bst_lfsr_reg <= lfsr_step(bst_lfsr_reg);
            crc_reg      <= crc_next;
            bst_cnt_reg  <= bst_cnt_reg + 9'h001;
            if (bst_cnt_reg == `ACB_BST_LAST) begin
                bst_run_reg  <= 1'b0;
                bst_pass_reg <= (crc_next == GOLDEN);
            end
        end
    end

    a_bist_length: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $fell(bst_run_reg) |-> $past(bst_cnt_reg) == `ACB_BST_LAST)
        else $error("self-test did not run 512 cycles");

    a_bist_verdict: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $fell(bst_run_reg) |-> bst_pass_reg == ($past(crc_next) == GOLDEN))
        else $error("self-test result disagrees with signature");

    a_bist_restart: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (bst_start && shadow_reg.bist[`ACB_BST_RST_BIT]) |=> bst_lfsr_reg == `ACB_BST_SEED)
        else $error("generator not restarted on start");

    a_bist_continue: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (bst_start && !shadow_reg.bist[`ACB_BST_RST_BIT]) |=> bst_lfsr_reg == $past(bst_lfsr_reg))
        else $error("generator not continued from last value");

    // ****************************************
    // output pattern generators
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            prs_long_reg  <= `ACB_PRS_LONG_SEED;
            prs_short_reg <= `ACB_PRS_SHRT_SEED;
            tog_reg       <= 1'b0;
        end else begin
            tog_reg       <= ~tog_reg;
            prs_long_reg  <= (xfer_evt && shadow_reg.pattern[`ACB_PAT_RST_LONG]) ? `ACB_PRS_LONG_SEED
                             : {prs_long_reg[21:0], prs_long_reg[22] ^ prs_long_reg[17]};
            prs_short_reg <= (xfer_evt && shadow_reg.pattern[`ACB_PAT_RST_SHORT]) ? `ACB_PRS_SHRT_SEED
                             : {prs_short_reg[7:0], prs_short_reg[8] ^ prs_short_reg[4]};
        end
    end

    always_comb begin
        case (acb_pat_e'(act_reg.pattern[3:0]))
            ACB_PAT_MID:      pat_word = `ACB_MIDSCALE;
            ACB_PAT_POS:      pat_word = 14'h3fff;
            ACB_PAT_NEG:      pat_word = 14'h0000;
            ACB_PAT_CHECK:    pat_word = tog_reg ? `ACB_CHECKER : ~`ACB_CHECKER;
            ACB_PAT_PRS_LONG: pat_word = prs_long_reg[13:0];
            ACB_PAT_PRS_SHRT: pat_word = {prs_short_reg, prs_short_reg[4:0]};
            ACB_PAT_TOGGLE:   pat_word = {14{tog_reg}};
            default:          pat_word = sample_i;
        endcase
    end

    // ****************************************
    // output formatter
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            data_reg <= 14'h0000;
        end else if (bst_run_reg) begin
            data_reg <= bst_lfsr_reg[13:0];
        end else begin
            data_reg <= {pat_word[13] ^ strap_reg.twos, pat_word[12:0]};
        end
    end
    assign data_o = data_reg;

    a_bist_visible: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        bst_run_reg |=> data_reg == $past(bst_lfsr_reg[13:0]))
        else $error("generator words not on the outputs");

    a_pattern_route: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (!bst_run_reg && act_reg.pattern[3:0] == 4'h1 && !strap_reg.twos) |=> data_reg == `ACB_MIDSCALE)
        else $error("pattern not routed to outputs");

    // ****************************************
    // straps caught after reset release
    // ****************************************
    always_ff @(posedge clock_i) begin
        pin_sel_reg <= {pin_sel_reg[0], port_select_bar_i};
        pin_dio_reg <= {pin_dio_reg[0], data_io_or_powerdown_strap_pin_i};
        pin_clk_reg <= {pin_clk_reg[0], clock_or_format_strap_pin_i};
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            strap_cnt_reg <= 2'h0;
            strap_reg     <= 3'h0;
        end else if (strap_cnt_reg != 2'h3) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == 2'h2) begin
                strap_reg.strap_mode <= pin_sel_reg[1];
                strap_reg.powerdown  <= pin_sel_reg[1] & pin_dio_reg[1];
                strap_reg.twos       <= pin_sel_reg[1] & pin_clk_reg[1];
            end
        end
    end

    assign powerdown_strap_o     = strap_reg.powerdown;
    assign format_select_strap_o = strap_reg.twos;
    assign strap_mode_o          = strap_reg.strap_mode;
    assign bist_running_o        = bst_run_reg;

endmodule : acb_spi_bist

// *** test/acb_host_model.sv ***
// serial host model for the three-wire control port
`timescale 1ns/10ps

module acb_host_model (
    // serial pins
    output logic      sclk_o,
    output logic      sel_n_o,
    output logic      sdo_o,
    input  wire logic sdi_i
);
    // shift order of the frames sent
    logic lsb = 1'b0;

    initial begin
        sclk_o  = 1'b0;
        sel_n_o = 1'b1;
        sdo_o   = 1'b0;
    end

    // one frame of instruction then one byte, 80 ns clock
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [23:0] f;
        int          i;
        f = {rd, 2'b00, a, wd};
        #3;
        sel_n_o = 1'b0;
        for (int k = 0; k < 24; k++) begin
            i = lsb ? (k < 16 ? k + 8 : k - 16) : 23 - k;
            sdo_o = (rd && i < 8) ? ~sdo_o : f[i];
            #40;
            if (i < 8) q[i] = sdi_i;
            sclk_o = 1'b1;
            #40;
            sclk_o = 1'b0;
        end
        sel_n_o = 1'b1;
        #77;
    endtask : xfer
endmodule : acb_host_model

// *** test/testbench.sv ***
// self-checking bench for the control port and self-test
`timescale 1ns/10ps
`include "acb_params.svh"

module testbench;
    logic        clock_i   = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        sclk, sel_n, sdo, dout, oe, pd, fmt, smode, run;
    logic [13:0] data;
    logic [7:0]  rv;
    logic [13:0] pexp [4] = '{14'h0123, `ACB_MIDSCALE, 14'h3fff, 14'h0000};
    int          n_mismatch = 0, compares = 0, ticks = 0, cnt = 0, chg = 0;
    wire logic   pin = oe ? dout : sdo;

    always #5 clock_i = ~clock_i;
    acb_host_model host (.sclk_o(sclk), .sel_n_o(sel_n), .sdo_o(sdo), .sdi_i(pin));
    acb_spi_bist DUT (.clock_i(clock_i), .reset_n_i(reset_n_i), .clock_or_format_strap_pin_i(sclk),
        .port_select_bar_i(sel_n), .data_io_or_powerdown_strap_pin_i(pin),
        .data_io_or_powerdown_strap_pin_o(dout), .data_io_or_powerdown_strap_pin_oe_o(oe),
        .sample_i(14'h0123), .data_o(data), .powerdown_strap_o(pd), .format_select_strap_o(fmt),
        .strap_mode_o(smode), .bist_running_o(run));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, rv);
    endtask : wr

    task automatic rd(input logic [12:0] a);
        host.xfer(1'b1, a, 8'h00, rv);
        check(oe, 1'b0);
    endtask : rd

    task automatic bist(input logic [7:0] ctl, input logic exp);
        wr(`ACB_ADDR_BST, ctl);
        check(run, 1'b0);
        cnt = 0;
        chg = 0;
        wr(`ACB_ADDR_XFER, `ACB_XFER_CMD);
        repeat (700) @(negedge clock_i);
        check(16'(cnt), 16'h0200);
        check(chg > 400, 1'b1);
        rd(`ACB_ADDR_RES);
        check(rv[0], exp);
        $display("self-test run %h done", ctl);
    endtask : bist

    always @(negedge clock_i) begin
        if (run === 1'b1) begin
            cnt++;
            chg += (data !== 14'h0123);
        end
    end

    always @(posedge clock_i) begin
        ticks++;
        if (ticks == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        for (int v = 1; v >= 0; v--) begin
            @(negedge clock_i);
            host.sclk_o = v[0];
            host.sdo_o = v[0];
            reset_n_i = 1'b0;
            repeat (5) @(negedge clock_i);
            reset_n_i = 1'b1;
            repeat (6) @(negedge clock_i);
            check({smode, pd, fmt}, {1'b1, v[0], v[0]});
            host.sclk_o = 1'b0;
            $display("strap test %0d done", v);
        end
        rd(`ACB_ADDR_CFG);
        check(rv, `ACB_CFG_RESET);
        rd(`ACB_ADDR_ID);
        check(rv, `ACB_CHIP_ID);
        rd(`ACB_ADDR_XFER);
        check(rv, 8'h00);
        wr(`ACB_ADDR_CFG, 8'h42);
        host.lsb = 1'b1;
        rd(`ACB_ADDR_CFG);
        check(rv, 8'h5a);
        wr(`ACB_ADDR_CFG, 8'h00);
        host.lsb = 1'b0;
        rd(`ACB_ADDR_CFG);
        check(rv, `ACB_CFG_RESET);
        $display("register test done");
        bist(8'h05, 1'b1);
        bist(8'h01, 1'b0);
        wr(`ACB_ADDR_BST, 8'h00);
        for (int p = 0; p < 4; p++) begin
            wr(`ACB_ADDR_PAT, 8'(p));
            check(data, pexp[p == 0 ? 0 : p - 1]);
            wr(`ACB_ADDR_XFER, `ACB_XFER_CMD);
            check(data, pexp[p]);
        end
        $display("pattern test done");
        complete_run();
    end
endmodule : testbench
